// ==== core/ch6_regs.vh ====
`ifndef CH6_REGS_VH
`define CH6_REGS_VH

// register indices; the byte address is four times the index
`define CTL_INDEX           8'h29
`define DIV_INDEX           8'h2A
`define CTL_ADDR            12'h0A4
`define DIV_ADDR            12'h0A8

// control register fields
`define SRC_MSB             7
`define SRC_LSB             6
`define FMT_MSB             5
`define FMT_LSB             4
`define MODE1_MSB           3
`define MODE1_LSB           2
`define MODE2_MSB           1
`define MODE2_LSB           0

`define CTL_RESET           8'h18
`define DIV_RESET           8'h05

// source codes
`define SRC_SYNTH_ONE       2'h0
`define SRC_SYNTH_TWO       2'h1
`define SRC_PRIMARY_REF     2'h2
`define SRC_SECONDARY_REF   2'h3

// driver format codes
`define FMT_DISABLED        2'h0
`define FMT_AC_DIFF         2'h1
`define FMT_HCSL            2'h2
`define FMT_CMOS            2'h3

// cmos pin mode codes
`define PIN_OFF_HIZ         2'h0
`define PIN_OFF_LOW         2'h1
`define PIN_RUN_INV         2'h2
`define PIN_RUN_TRUE        2'h3

`endif

// ==== core/channel_divider.v ====
// divides a sampled clock level by ratio_code + 1, counting its rising edges
module channel_divider (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       src_i,
    input  wire [7:0] ratio_code_i,
    output reg        div_o
);
    reg  [7:0] count_reg;
    reg        src_last_reg;
    wire [8:0] ratio;
    wire [8:0] half;
    wire       rise;

    assign ratio = {1'b0, ratio_code_i} + 9'h001;
    assign half  = (ratio + 9'h001) >> 1;
    assign rise  = src_i & ~src_last_reg;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_reg    <= 8'h00;
            src_last_reg <= 1'b0;
            div_o        <= 1'b0;
        end else begin
            src_last_reg <= src_i;
            if (ratio_code_i == 8'h00) begin
                // ratio of one: the source passes straight through
                div_o     <= src_i;
                count_reg <= 8'h00;
            end else if (rise) begin
                // a shrinking ratio could leave the count beyond the end; wrap at once
                if (count_reg >= ratio_code_i) begin
                    count_reg <= 8'h00;
                    div_o     <= 1'b1;
                end else begin
                    count_reg <= count_reg + 8'h01;
                    div_o     <= ({1'b0, count_reg} + 9'h001) < half;
                end
            end
        end
    end
endmodule // channel_divider

// ==== core/output_channel_six_control.v ====
// Notes on behaviour
// - the two-bit source select routes synthesizer one, synthesizer two, primary or secondary reference for codes 0 to 3, resetting to synthesizer one.
// - with the doubler on, a reference source delivers the doubled reference instead of the plain one.
// - a reference source goes straight to the driver and skips the divider whatever its code.
// - the format field disables the output for 0, picks AC differential for 1, HCSL for 2 and CMOS for 3, resetting to 1.
// - in CMOS the primary mode field sets the positive pin to off-hiz, off-low, inverted or true; in differential it picks tail current.
// - in CMOS the secondary mode field sets the negative pin the same way; in HCSL it picks the load hiz, 50, 100 or 200 ohms.
// - the divide code gives a ratio of code plus one, resetting to 0x05.
`include "ch6_regs.vh"

module output_channel_six_control (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        synth_one_clk_i,
    input  wire        synth_two_clk_i,
    input  wire        primary_ref_i,
    input  wire        secondary_ref_i,
    input  wire        primary_ref_x2_i,
    input  wire        secondary_ref_x2_i,
    input  wire        doubler_enable_i,
    output reg         out_p_o,
    output reg         out_p_oe_o,
    output reg         out_n_o,
    output reg         out_n_oe_o,
    output reg  [1:0]  driver_format_o,
    output reg  [1:0]  tail_current_sel_o,
    output reg  [1:0]  hcsl_load_sel_o
);
    reg  [7:0] channel_six_output_control_reg;
    reg  [7:0] channel_six_output_divider_reg;
    reg  [6:0] sync1_reg;
    reg  [6:0] sync2_reg;
    reg        src_clk;
    wire [6:0] raw_in;
    wire       div_clk;
    wire       chan_clk;
    wire [1:0] channel_source_select;
    wire [1:0] driver_format;
    wire [1:0] driver_primary_mode;
    wire [1:0] driver_secondary_mode;
    wire       is_ref;
    wire       access;
    wire       wr;
    wire       ctl_wr;
    wire       div_wr;

    // bit positions in the synchroniser; they must follow the order of raw_in
    localparam SYNC_SYNTH_ONE    = 0;
    localparam SYNC_SYNTH_TWO    = 1;
    localparam SYNC_PRIMARY      = 2;
    localparam SYNC_SECONDARY    = 3;
    localparam SYNC_PRIMARY_X2   = 4;
    localparam SYNC_SECONDARY_X2 = 5;
    localparam SYNC_DOUBLER      = 6;

    // shared by the write strobe and the error flag
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `CTL_ADDR) || (a == `DIV_ADDR);
        end
    endfunction

    // cmos leg decode, shared by the positive and the negative leg
    function pin_drives;
        input [1:0] mode;
        begin
            // only the tri-state code releases the leg
            pin_drives = (mode != `PIN_OFF_HIZ);
        end
    endfunction

    function pin_level;
        input [1:0] mode;
        input       clk;
        begin
            // both powered-down codes hold the leg low
            case (mode)
                `PIN_RUN_TRUE: pin_level = clk;
                `PIN_RUN_INV:  pin_level = ~clk;
                default:       pin_level = 1'b0;
            endcase
        end
    endfunction

    // the doubler enable is synchronised with the clocks it selects, so both move together
    assign raw_in = {doubler_enable_i, secondary_ref_x2_i, primary_ref_x2_i, secondary_ref_i,
                     primary_ref_i, synth_two_clk_i, synth_one_clk_i};

    // every pin source passes two flops; the first stage feeds only the second
    // sampled clocks must stay well below half of ref_clk_i, or edges are lost
    // both stages reset low, the idle level of every source
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign channel_source_select = channel_six_output_control_reg[`SRC_MSB:`SRC_LSB];
    assign driver_format         = channel_six_output_control_reg[`FMT_MSB:`FMT_LSB];
    assign driver_primary_mode   = channel_six_output_control_reg[`MODE1_MSB:`MODE1_LSB];
    assign driver_secondary_mode = channel_six_output_control_reg[`MODE2_MSB:`MODE2_LSB];

    // apb slave: zero wait states, error on unmapped addresses
    assign access  = psel & penable;
    // a write with the low strobe clear is dropped, as only byte 0 holds a field
    assign wr      = access & pwrite & is_mapped(paddr) & pstrb[0];
    assign ctl_wr  = wr & (paddr == `CTL_ADDR);
    assign div_wr  = wr & (paddr == `DIV_ADDR);
    assign pready  = 1'b1;
    assign pslverr = access & ~is_mapped(paddr);

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            channel_six_output_control_reg <= `CTL_RESET;
            channel_six_output_divider_reg <= `DIV_RESET;
        end else begin
            if (ctl_wr) begin
                channel_six_output_control_reg <= pwdata[7:0];
            end
            if (div_wr) begin
                channel_six_output_divider_reg <= pwdata[7:0];
            end
        end
    end

    // read data is loaded in the setup phase, so with no wait states it still
    // comes from a flop and stands through the whole access phase
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable) begin
            if (paddr == `CTL_ADDR) begin
                prdata <= {24'h000000, channel_six_output_control_reg};
            end else if (paddr == `DIV_ADDR) begin
                prdata <= {24'h000000, channel_six_output_divider_reg};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // source mux
    always @* begin
        case (channel_source_select)
            `SRC_SYNTH_ONE:   src_clk = sync2_reg[SYNC_SYNTH_ONE];
            `SRC_SYNTH_TWO:   src_clk = sync2_reg[SYNC_SYNTH_TWO];
            `SRC_PRIMARY_REF: src_clk = sync2_reg[SYNC_DOUBLER] ? sync2_reg[SYNC_PRIMARY_X2]
                                                                 : sync2_reg[SYNC_PRIMARY];
            default:          src_clk = sync2_reg[SYNC_DOUBLER] ? sync2_reg[SYNC_SECONDARY_X2]
                                                                 : sync2_reg[SYNC_SECONDARY];
        endcase
    end

    // the divider keeps counting while bypassed, so a return to a synthesizer needs no restart
    channel_divider u_div (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .src_i        (src_clk),
        .ratio_code_i (channel_six_output_divider_reg),
        .div_o        (div_clk)
    );

    // the divided path carries one flop of latency; the bypass is used as is
    assign is_ref   = channel_source_select[1];
    assign chan_clk = is_ref ? src_clk : div_clk;
    // pins are released during reset and take the configured format one edge later

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            out_p_o            <= 1'b0;
            out_p_oe_o         <= 1'b0;
            out_n_o            <= 1'b0;
            out_n_oe_o         <= 1'b0;
            driver_format_o    <= 2'h0;
            tail_current_sel_o <= 2'h0;
            hcsl_load_sel_o    <= 2'h0;
        end else begin
            // the selects read zero in formats where the field has no meaning
            driver_format_o    <= driver_format;
            tail_current_sel_o <= (driver_format == `FMT_AC_DIFF || driver_format == `FMT_HCSL)
                                  ? driver_primary_mode : 2'h0;
            hcsl_load_sel_o    <= (driver_format == `FMT_HCSL) ? driver_secondary_mode : 2'h0;
            case (driver_format)
                `FMT_DISABLED: begin
                    // both legs released
                    out_p_o    <= 1'b0;
                    out_p_oe_o <= 1'b0;
                    out_n_o    <= 1'b0;
                    out_n_oe_o <= 1'b0;
                end
                `FMT_CMOS: begin
                    out_p_oe_o <= pin_drives(driver_primary_mode);
                    out_p_o    <= pin_level(driver_primary_mode, chan_clk);
                    out_n_oe_o <= pin_drives(driver_secondary_mode);
                    out_n_o    <= pin_level(driver_secondary_mode, chan_clk);
                end
                default: begin
                    // differential pair: complementary legs
                    // the mode fields reach the driver only through the exported selects
                    out_p_o    <= chan_clk;
                    out_p_oe_o <= 1'b1;
                    out_n_o    <= ~chan_clk;
                    out_n_oe_o <= 1'b1;
                end
            endcase
        end
    end
endmodule // output_channel_six_control

// ==== dv/ch6_properties.sv ====
module ch6_properties (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        out_p_o,
    input wire logic        out_p_oe_o,
    input wire logic        out_n_oe_o,
    input wire logic [1:0]  driver_format_o,
    input wire logic [1:0]  tail_current_sel_o,
    input wire logic [1:0]  hcsl_load_sel_o
);
    logic [7:0] ctl_reg, div_reg;
    wire        wr = psel && penable && pwrite && pstrb[0] && paddr == 12'h0A4;
    wire        wr_div = psel && penable && pwrite && pstrb[0] && paddr == 12'h0A8;
    // shadow copies let the pin and readback checks follow software writes
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl_reg <= 8'h18;
            div_reg <= 8'h05;
        end else begin
            if (wr)
                ctl_reg <= pwdata[7:0];
            if (wr_div)
                div_reg <= pwdata[7:0];
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_format_copy: assert property (!$past(rst_i) |-> driver_format_o == $past(ctl_reg[5:4]))
        else $error("format mismatch");
    a_tail_select: assert property (!$past(rst_i) |-> tail_current_sel_o ==
        ($past(ctl_reg[5:4]) inside {2'h1, 2'h2} ? $past(ctl_reg[3:2]) : 2'h0))
        else $error("tail select mismatch");
    a_load_select: assert property (!$past(rst_i) |-> hcsl_load_sel_o ==
        ($past(ctl_reg[5:4]) == 2'h2 ? $past(ctl_reg[1:0]) : 2'h0))
        else $error("load select mismatch");
    a_p_driven_low: assert property (!$past(rst_i) && $past(ctl_reg[5:2]) == 4'hD
        |-> out_p_oe_o && !out_p_o)
        else $error("positive pin not low");
    a_n_off_hiz: assert property (!$past(rst_i) && $past(ctl_reg[5:4]) == 2'h3
        && $past(ctl_reg[1:0]) == 2'h0 |-> !out_n_oe_o)
        else $error("negative pin driven");
    a_off_no_drive: assert property (!$past(rst_i) && $past(ctl_reg[5:4]) == 2'h0
        |-> !out_p_oe_o && !out_n_oe_o)
        else $error("disabled output driven");
    a_ctl_readback: assert property (psel && penable && !pwrite && paddr == 12'h0A4
        |-> prdata == {24'h0, ctl_reg})
        else $error("control readback");
    a_div_readback: assert property (psel && penable && !pwrite && paddr == 12'h0A8
        |-> prdata == {24'h0, div_reg})
        else $error("divider readback");
endmodule // ch6_properties

bind output_channel_six_control ch6_properties u_chk (.ref_clk_i, .rst_i, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .out_p_o, .out_p_oe_o, .out_n_oe_o,
    .driver_format_o, .tail_current_sel_o, .hcsl_load_sel_o);

// ==== dv/tb_output_channel_six_control.sv ====
module tb_output_channel_six_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, dbl = 0, prev;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, lfsr = 32'h248E;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  cnt = 0, dv;
    logic [1:0]  s;
    logic        er, prev_n;
    wire  [31:0] prdata;
    wire         pready, pslverr, out_p_o, out_n_o;
    int          mismatches = 0, samples_checked = 0, cycles = 0, n, m;
    always #2.5 ref_clk_i = ~ref_clk_i;
    // counter bits give source clocks of periods 32, 16, 8 and 4 cycles
    always @(posedge ref_clk_i) begin
        cnt <= cnt + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    output_channel_six_control dut (.ref_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .synth_one_clk_i(cnt[4]),
        .synth_two_clk_i(cnt[3]), .primary_ref_i(cnt[2]), .secondary_ref_i(cnt[3]),
        .primary_ref_x2_i(cnt[1]), .secondary_ref_x2_i(cnt[2]), .doubler_enable_i(dbl),
        .out_p_o, .out_p_oe_o(), .out_n_o, .out_n_oe_o(), .driver_format_o(),
        .tail_current_sel_o(), .hcsl_load_sel_o());
    task automatic report_and_stop();
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] st);
        @(posedge ref_clk_i);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge ref_clk_i);
        penable <= 1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [31:0] nx(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction
    // rising edges of the pin over 256 cycles; references skip the divider
    function automatic int edges(input logic [1:0] sc, input logic [7:0] d, input logic db);
        int p;
        p = sc == 2'h0 ? 32 : sc == 2'h2 ? (db ? 4 : 8) : (sc == 2'h3 && db) ? 8 : 16;
        return sc[1] ? 256 / p : 256 / (p * (d + 1));
    endfunction
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 0;
        apb(0, 12'h0A4, 0, 4'hF);
        chk(rd, 32'h18);
        apb(1, 12'h0A8, 32'hFF, 4'h0);
        apb(0, 12'h0A8, 0, 4'hF);
        chk(rd, 32'h05);
        apb(0, 12'h0B0, 0, 4'hF);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1, 12'h0A8, 32'hFF, 4'hF);
        apb(0, 12'h0A8, 0, 4'hF);
        chk(rd, 32'hFF);
        chk(er, 1'b0);
        // cmos with the positive leg parked low and the negative leg released
        apb(1, 12'h0A4, 32'h34, 4'hF);
        repeat (8) @(negedge ref_clk_i);
        chk(out_p_o, 1'b0);
        chk(out_n_o, 1'b0);
        for (int i = 0; i < 16; i++) begin
            lfsr = nx(lfsr);
            apb(1, 12'h0A4, {24'h0, lfsr[7:6], i[1:0], lfsr[3:0]}, 4'hF);
            repeat (6) @(posedge ref_clk_i);
            s = lfsr[9:8];
            dv = lfsr[11] ? 8'h03 : {7'h0, lfsr[10]};
            dbl <= lfsr[12];
            apb(1, 12'h0A8, {24'h0, dv}, 4'hF);
            apb(1, 12'h0A4, {24'h0, s, 6'h3E}, 4'hF);
            repeat (40) @(negedge ref_clk_i);
            n = 0;
            m = 0;
            prev = out_p_o;
            prev_n = out_n_o;
            repeat (256) begin
                @(negedge ref_clk_i);
                if (out_p_o && !prev)
                    n++;
                if (out_n_o && !prev_n)
                    m++;
                prev = out_p_o;
                prev_n = out_n_o;
            end
            chk(n, edges(s, dv, dbl));
            chk(m, edges(s, dv, dbl));
        end
        // a second reset in mid-run brings back the reset values
        @(posedge ref_clk_i);
        rst_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 0;
        apb(0, 12'h0A4, 0, 4'hF);
        chk(rd, 32'h18);
        apb(0, 12'h0A8, 0, 4'hF);
        chk(rd, 32'h05);
        report_and_stop();
    end
endmodule // tb_output_channel_six_control
